// ### verilog/sfpc_pkg.sv
package sfpc_pkg;

	// ==========================================================
	// Variants
	typedef enum logic [1:0] {
		SFPC_VAR_ADJ_BASIC,
		SFPC_VAR_ADJ_FOLD,
		SFPC_VAR_FIXED
	} sfpc_variant_t;

	// ==========================================================
	// Timing
	localparam int SFPC_CLK_MHZ        = 125;
	localparam int SFPC_DEGLITCH_NS    = 3000;
	localparam int SFPC_DEGLITCH_CYC   =
		(SFPC_DEGLITCH_NS * SFPC_CLK_MHZ + 999) / 1000;
	localparam int SFPC_RETRY_US       = 1000;
	localparam int SFPC_RETRY_CYC      = SFPC_RETRY_US * SFPC_CLK_MHZ;

	// ==========================================================
	// Foldback and limits
	localparam int SFPC_FOLD_COUNT     = 7;
	localparam int SFPC_CNT_W          = 3;
	localparam int SFPC_LIMIT_SET_PIN_W         = 12;
	localparam int SFPC_TEMP_W         = 9;
	localparam int SFPC_RES_MIN_KOHM   = 5;
	localparam int SFPC_RES_MAX_KOHM   = 25;
	localparam int SFPC_TFLAT_C        = 60;
	localparam int SFPC_TEND_C         = 150;

endpackage : sfpc_pkg

// ### verilog/sfpc_fault_ctrl.sv
`timescale 1ns/1ns
// Behaviour
// - Thermal or overcurrent fault: switch off, fault
// - Fault state drives sense fault level, flag in fixed variant only
// - Release needs holdoff low, retry done, clear
// - Thermal fault on absolute or relative limit
// - Absolute fault holds until hysteresis below limit
// - Relative fault clears after retry delay
// - Overcurrent threshold held through the deglitch: switch off
// - Overcurrent deglitched over three microseconds
// - Seven consecutive faults halve threshold
// - Standby or clean cycle restores threshold
// - Basic adjustable variant never folds back
// - Fixed limit derates between 60 and 150
// - Bad limit resistor selects default threshold
// - Undervoltage shuts output, resumes on rise
// - Load dump masks undervoltage shutoff, trips still switch off
// - Reverse battery forces switch on
// - Fault flag asserted with sense fault level, fixed variant only
// - Retry fault indication until output risen
module sfpc_fault_ctrl #(
	parameter sfpc_pkg::sfpc_variant_t VARIANT = sfpc_pkg::SFPC_VAR_ADJ_FOLD,
	parameter int RETRY_CYC     = sfpc_pkg::SFPC_RETRY_CYC,
	parameter int DEGLITCH_CYC  = sfpc_pkg::SFPC_DEGLITCH_CYC,
	parameter int FOLD_COUNT    = sfpc_pkg::SFPC_FOLD_COUNT,
	parameter int LIMIT_SET_PIN_W        = sfpc_pkg::SFPC_LIMIT_SET_PIN_W,
	parameter int TEMP_W        = sfpc_pkg::SFPC_TEMP_W
) (
	// Clock and reset
	input  wire logic              mclk_in,
	input  wire logic              resetn_in,
	// Host control pins
	input  wire logic              enable_in,
	input  wire logic              diagnostics_enable_in,
	input  wire logic              holdoff_in,
	// Analog monitor comparators
	input  wire logic              abs_over_in,
	input  wire logic              abs_hys_clear_in,
	input  wire logic              rel_over_in,
	input  wire logic              supply_below_fall_in,
	input  wire logic              supply_above_rise_in,
	input  wire logic              reverse_battery_in,
	input  wire logic              load_dump_in,
	input  wire logic              vout_risen_in,
	// Current and temperature measures
	input  wire logic [LIMIT_SET_PIN_W-1:0] current_in,
	input  wire logic [TEMP_W-1:0] junction_temp_in,
	input  wire logic [7:0]        limit_set_resistor_in,
	input  wire logic [LIMIT_SET_PIN_W-1:0] default_threshold_in,
	input  wire logic [LIMIT_SET_PIN_W-1:0] limit_k_in,
	// Outputs
	output logic                   switch_on_out,
	output logic                   sense_fault_out,
	output logic                   fault_flag_n_oe_out,
	output logic                   fault_flag_n_out,
	output logic [LIMIT_SET_PIN_W-1:0]      overcurrent_threshold_out,
	output logic                   fault_state_out,
	output logic                   foldback_active_out
);

	// ==========================================================
	// Elaboration checks
	// Fold counter is three bits wide, so the count must fit in it
	if (RETRY_CYC < 1 || DEGLITCH_CYC < 1 || FOLD_COUNT < 1 ||
	    FOLD_COUNT > 7) begin : g_bad_param
		$error("sfpc_fault_ctrl: bad parameter");
	end

	localparam int RW = $clog2(RETRY_CYC + 1);
	localparam int DW = $clog2(DEGLITCH_CYC + 1);
	localparam logic [RW-1:0] RETRY_END = RW'(RETRY_CYC);
	localparam logic [DW-1:0] DGL_END   = DW'(DEGLITCH_CYC);
	localparam logic [2:0]    FOLD_END  = 3'(FOLD_COUNT);
	localparam logic [7:0]    RES_MIN   = 8'(sfpc_pkg::SFPC_RES_MIN_KOHM);
	localparam logic [7:0]    RES_MAX   = 8'(sfpc_pkg::SFPC_RES_MAX_KOHM);
	localparam logic [TEMP_W-1:0] T_FLAT = TEMP_W'(sfpc_pkg::SFPC_TFLAT_C);
	localparam logic [TEMP_W-1:0] T_END  = TEMP_W'(sfpc_pkg::SFPC_TEND_C);
	localparam logic [TEMP_W-1:0] T_SPAN =
		TEMP_W'(sfpc_pkg::SFPC_TEND_C - sfpc_pkg::SFPC_TFLAT_C);

	// ==========================================================
	// Input synchronisers, two flops each
	// Bits 1:0 are spare; the diagnostics bit is kept for later use
	// Only the second flop of each pair feeds any logic
	localparam int NS = 13;
	logic [NS-1:0] raw_w;
	logic [NS-1:0] s1_r;
	logic [NS-1:0] s2_r;
	assign raw_w = {enable_in, diagnostics_enable_in, holdoff_in,
		abs_over_in, abs_hys_clear_in, rel_over_in, supply_below_fall_in,
		supply_above_rise_in, reverse_battery_in, load_dump_in,
		vout_risen_in, 2'h0};

	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			s1_r <= '0;
			s2_r <= '0;
		end else begin
			s1_r <= raw_w;
			s2_r <= s1_r;
		end
	end

	logic en_w, hold_w, abs_w, hys_w, rel_w, uvf_w, uvr_w;
	logic rev_w, dump_w, risen_w;
	assign en_w    = s2_r[12];
	assign hold_w  = s2_r[10];
	assign abs_w   = s2_r[9];
	assign hys_w   = s2_r[8];
	assign rel_w   = s2_r[7];
	assign uvf_w   = s2_r[6];
	assign uvr_w   = s2_r[5];
	assign rev_w   = s2_r[4];
	assign dump_w  = s2_r[3];
	assign risen_w = s2_r[2];

	// Measured values, two flops each
	// Slowly moving measures; a one-cycle skew between bits is harmless
	logic [LIMIT_SET_PIN_W-1:0] cur1_r, cur2_r;
	logic [TEMP_W-1:0] tj1_r, tj2_r;
	logic [7:0]        res1_r, res2_r;
	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			cur1_r <= '0;
			cur2_r <= '0;
			tj1_r  <= '0;
			tj2_r  <= '0;
			res1_r <= '0;
			res2_r <= '0;
		end else begin
			cur1_r <= current_in;
			cur2_r <= cur1_r;
			tj1_r  <= junction_temp_in;
			tj2_r  <= tj1_r;
			res1_r <= limit_set_resistor_in;
			res2_r <= res1_r;
		end
	end

	// ==========================================================
	// Threshold selection
	logic              res_ok_w;
	logic [LIMIT_SET_PIN_W-1:0] adj_thr_w;
	logic [LIMIT_SET_PIN_W-1:0] base_thr_w;
	logic [LIMIT_SET_PIN_W-1:0] derate_w;
	logic [2*LIMIT_SET_PIN_W-1:0] derate_prod_w;
	logic [TEMP_W-1:0] over_w;
	logic              fold_r;

	// Resistor out of range falls back to default
	// Divider is large but its operands barely move, so no pipeline
	assign res_ok_w  = (res2_r >= RES_MIN) && (res2_r <= RES_MAX);
	assign adj_thr_w = res_ok_w ?
		LIMIT_SET_PIN_W'(limit_k_in / LIMIT_SET_PIN_W'(res2_r)) : default_threshold_in;

	// Flat to 60 C then linear fall to zero at 150 C
	assign over_w = (tj2_r <= T_FLAT) ? '0 :
		(tj2_r >= T_END) ? T_SPAN : TEMP_W'(tj2_r - T_FLAT);
	assign derate_prod_w = default_threshold_in * (T_SPAN - over_w);
	assign derate_w = LIMIT_SET_PIN_W'(derate_prod_w / T_SPAN);

	assign base_thr_w = (VARIANT == sfpc_pkg::SFPC_VAR_FIXED) ?
		derate_w : adj_thr_w;
	// Halved while folded back
	assign overcurrent_threshold_out = fold_r ?
		(base_thr_w >> 1) : base_thr_w;

	// ==========================================================
	// Overcurrent deglitch
	// Any dip below threshold restarts the count, so spikes never trip
	logic [DW-1:0] dgl_r;
	logic          oc_raw_w;
	logic          oc_w;
	assign oc_raw_w = cur2_r >= overcurrent_threshold_out;
	assign oc_w     = oc_raw_w && (dgl_r == DGL_END);

	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in)
			dgl_r <= '0;
		else if (!oc_raw_w)
			dgl_r <= '0;
		else if (dgl_r != DGL_END)
			dgl_r <= dgl_r + 1'b1;
	end

	// ==========================================================
	// Fault state machine
	typedef enum logic [1:0] {
		SFPC_OFF, SFPC_ON, SFPC_FAULT, SFPC_RETRY
	} sfpc_state_t;

	// Decode of states in which the switch conducts
	function automatic logic conducts(input sfpc_state_t s);
		return (s == SFPC_ON) || (s == SFPC_RETRY);
	endfunction : conducts

	// Decode of states that show the fault level
	function automatic logic shows_fault(input sfpc_state_t s);
		return (s == SFPC_FAULT) || (s == SFPC_RETRY);
	endfunction : shows_fault

	sfpc_state_t state_r, state_nxt;
	logic [RW-1:0] retry_r;
	logic          abs_flt_r, rel_flt_r;
	logic          uvlo_r;
	logic          retry_done_w, faults_clear_w, trip_w, release_w;

	assign retry_done_w   = retry_r == RETRY_END;
	assign faults_clear_w = !abs_flt_r && !rel_flt_r && !oc_raw_w;
	// Reverse battery masks trips so the forced-on switch stays on
	assign trip_w = (abs_w || rel_w || oc_w) && !rev_w;
	assign release_w = !hold_w && retry_done_w && faults_clear_w;

	// Next state
	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			SFPC_OFF: begin
				if (en_w && !uvlo_r)
					state_nxt = SFPC_ON;
			end
			SFPC_ON: begin
				if (trip_w)
					state_nxt = SFPC_FAULT;
				else if (!en_w || uvlo_r)
					state_nxt = SFPC_OFF;
			end
			SFPC_FAULT: begin
				if (release_w)
					state_nxt = en_w ? SFPC_RETRY : SFPC_OFF;
			end
			SFPC_RETRY: begin
				if (trip_w)
					state_nxt = SFPC_FAULT;
				else if (!en_w || uvlo_r)
					state_nxt = SFPC_OFF;
				else if (risen_w)
					state_nxt = SFPC_ON;
			end
		endcase
	end

	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in)
			state_r <= SFPC_OFF;
		else
			state_r <= state_nxt;
	end

	// Retry timer from fault entry
	// Cleared outside the fault state, so each entry counts afresh
	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in)
			retry_r <= '0;
		else if (state_r != SFPC_FAULT)
			retry_r <= '0;
		else if (!retry_done_w)
			retry_r <= retry_r + 1'b1;
	end

	// Thermal fault latches; set wins over clear
	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			abs_flt_r <= 1'b0;
			rel_flt_r <= 1'b0;
		end else begin
			if (abs_w)
				abs_flt_r <= 1'b1;
			else if (hys_w)
				abs_flt_r <= 1'b0;
			if (rel_w)
				rel_flt_r <= 1'b1;
			else if (retry_done_w)
				rel_flt_r <= 1'b0;
		end
	end

	// Undervoltage lockout with hysteresis
	// Starts locked so the switch waits for a good supply after reset
	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in)
			uvlo_r <= 1'b1;
		else if (uvf_w && !dump_w)
			uvlo_r <= 1'b1;
		else if (uvr_w)
			uvlo_r <= 1'b0;
	end

	// ==========================================================
	// Foldback counter
	// Fault entry wins over a clear in the same cycle
	logic [2:0] fcnt_r;
	logic       fault_entry_w, clean_off_w, standby_w, fold_ok_w;
	assign fault_entry_w = (state_r != SFPC_FAULT) &&
		(state_nxt == SFPC_FAULT);
	assign clean_off_w = (state_r == SFPC_ON) && (state_nxt == SFPC_OFF);
	assign standby_w = (state_r == SFPC_OFF) && !en_w;
	assign fold_ok_w = VARIANT != sfpc_pkg::SFPC_VAR_ADJ_BASIC;

	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			fcnt_r <= '0;
			fold_r <= 1'b0;
		end else if (fault_entry_w && fold_ok_w) begin
			if (fcnt_r != FOLD_END)
				fcnt_r <= fcnt_r + 1'b1;
			if (fcnt_r + 3'h1 >= FOLD_END)
				fold_r <= 1'b1;
		end else if (standby_w || clean_off_w) begin
			fcnt_r <= '0;
			fold_r <= 1'b0;
		end
	end

	// ==========================================================
	// Outputs
	logic sw_r, flt_r;
	logic sw_nxt, flt_nxt;

	// Reverse battery forces on
	assign sw_nxt  = rev_w || conducts(state_nxt);
	// Fault level in fault and retry
	assign flt_nxt = shows_fault(state_nxt);

	// Output flops, taken from the next state to save a cycle
	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			sw_r  <= 1'b0;
			flt_r <= 1'b0;
		end else begin
			sw_r  <= sw_nxt;
			flt_r <= flt_nxt;
		end
	end

	assign switch_on_out       = sw_r;
	assign sense_fault_out     = flt_r;
	assign fault_flag_n_out    = 1'b0;
	assign fault_flag_n_oe_out =
		(VARIANT == sfpc_pkg::SFPC_VAR_FIXED) && flt_r;
	assign fault_state_out     = state_r == SFPC_FAULT;
	assign foldback_active_out = fold_r;

endmodule : sfpc_fault_ctrl

// ### dv/sfpc_host_model.sv
`timescale 1ns/1ns
module sfpc_host_model (
	// Clock and reset
	input  wire logic mclk_in,
	input  wire logic resetn_in,
	// Requests from the bench
	input  wire logic supply_ok_in,
	input  wire logic want_en_in,
	input  wire logic want_hold_in,
	// Control pins
	output logic      enable_out,
	output logic      holdoff_out,
	output logic      diag_en_out
);
	logic seen_r;
	// ==========================================================
	// Ramp guard: enable low until supply first seen good
	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in)
			seen_r <= 1'b0;
		else if (supply_ok_in)
			seen_r <= 1'b1;
	end
	assign enable_out  = want_en_in && seen_r;
	assign holdoff_out = want_hold_in;
	assign diag_en_out = 1'b1;
endmodule : sfpc_host_model

// ### dv/sfpc_fault_ctrl_assertions.sv
`timescale 1ns/1ns
module sfpc_fault_ctrl_assertions #(
	parameter sfpc_pkg::sfpc_variant_t VARIANT = sfpc_pkg::SFPC_VAR_ADJ_FOLD,
	parameter int RETRY_CYC = 20, DEGLITCH_CYC = 375, LIMIT_SET_PIN_W = 12
) (
	// Clock, reset and watched pins
	input wire logic mclk_in, resetn_in, holdoff_in, abs_over_in,
	input wire logic reverse_battery_in, supply_below_fall_in, load_dump_in,
	input wire logic [LIMIT_SET_PIN_W-1:0] current_in, overcurrent_threshold_out,
	input wire logic switch_on_out, sense_fault_out, fault_flag_n_oe_out,
	input wire logic fault_flag_n_out, fault_state_out, foldback_active_out
);
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (!resetn_in);
	int fcnt_r;
	int ocnt_r;
	// ==========================================================
	// Fault length and overcurrent run counters
	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			fcnt_r <= 0;
			ocnt_r <= 0;
		end else begin
			fcnt_r <= fault_state_out ? fcnt_r + 1 : 0;
			ocnt_r <= (switch_on_out && !reverse_battery_in &&
				current_in >= overcurrent_threshold_out) ? ocnt_r + 1 : 0;
		end
	end
	sequence s_hold; holdoff_in[*4] ##0 fault_state_out; endsequence
	sequence s_rev; reverse_battery_in[*4]; endsequence
	property p_trip; $rose(abs_over_in) && switch_on_out && !reverse_battery_in
		|-> ##[1:5] (fault_state_out && !switch_on_out); endproperty
	property p_sense; $rose(fault_state_out) |-> ##[0:1] sense_fault_out;
	endproperty
	property p_flag; fault_flag_n_oe_out |-> !fault_flag_n_out &&
		VARIANT == sfpc_pkg::SFPC_VAR_FIXED; endproperty
	property p_hold; s_hold |=> fault_state_out; endproperty
	property p_retry; $fell(fault_state_out) |-> fcnt_r >= RETRY_CYC - 1;
	endproperty
	property p_oc; ocnt_r <= DEGLITCH_CYC + 6; endproperty
	property p_fold; $rose(foldback_active_out) |-> overcurrent_threshold_out
		== $past(overcurrent_threshold_out) >> 1; endproperty
	property p_basic; foldback_active_out |->
		VARIANT != sfpc_pkg::SFPC_VAR_ADJ_BASIC; endproperty
	property p_rev; s_rev |-> ##[0:2] switch_on_out; endproperty
	property p_uv; (supply_below_fall_in && !load_dump_in &&
		!reverse_battery_in)[*4] |=> !switch_on_out; endproperty
	a_trip: assert property (p_trip) else $error("no trip");
	a_sense: assert property (p_sense) else $error("no sense");
	a_flag: assert property (p_flag) else $error("bad flag");
	a_hold: assert property (p_hold) else $error("held off");
	a_retry: assert property (p_retry) else $error("short");
	a_oc: assert property (p_oc) else $error("no oc trip");
	a_fold: assert property (p_fold) else $error("no halve");
	a_basic: assert property (p_basic) else $error("fold");
	a_rev: assert property (p_rev) else $error("rev off");
	a_uv: assert property (p_uv) else $error("uv on");
endmodule : sfpc_fault_ctrl_assertions
bind sfpc_fault_ctrl sfpc_fault_ctrl_assertions #(.VARIANT(VARIANT),
	.RETRY_CYC(RETRY_CYC), .DEGLITCH_CYC(DEGLITCH_CYC), .LIMIT_SET_PIN_W(LIMIT_SET_PIN_W))
	u_chk (.*);

// ### dv/sfpc_fault_ctrl_tb.sv
`timescale 1ns/1ns
module sfpc_fault_ctrl_tb;
	localparam int RC = 20;
	logic        mclk_in = 0, resetn_in = 0, w_en = 0, w_hold = 0;
	logic        en, hold, diag, abs_o = 0, abs_c = 1, rel_o = 0;
	logic        s_lo = 0, s_hi = 0, rev = 0, ld = 0, vr = 0, chk = 0;
	logic [11:0] cur = 12'h000, thr;
	logic [7:0]  res = 8'h00;
	logic        sw, sf, oe, fo, fs, fb;
	logic        sw_f, sf_f, oe_f, fo_f, fs_f, fb_f;
	logic [11:0] thr_f;
	logic [8:0]  tj = 9'h019;
	logic [1:0]  q[$];
	logic [1:0]  e;
	int          n_fail = 0, comparisons = 0;
	always #4 mclk_in = ~mclk_in;
	sfpc_host_model host (.mclk_in(mclk_in), .resetn_in(resetn_in),
		.supply_ok_in(s_hi), .want_en_in(w_en), .want_hold_in(w_hold),
		.enable_out(en), .holdoff_out(hold), .diag_en_out(diag));
	sfpc_fault_ctrl #(.RETRY_CYC(RC)) uut (.mclk_in(mclk_in),
		.resetn_in(resetn_in), .enable_in(en), .diagnostics_enable_in(diag),
		.holdoff_in(hold), .abs_over_in(abs_o), .abs_hys_clear_in(abs_c),
		.rel_over_in(rel_o), .supply_below_fall_in(s_lo),
		.supply_above_rise_in(s_hi), .reverse_battery_in(rev),
		.load_dump_in(ld), .vout_risen_in(vr), .current_in(cur),
		.junction_temp_in(9'h019), .limit_set_resistor_in(res),
		.default_threshold_in(12'h200), .limit_k_in(12'hA00),
		.switch_on_out(sw), .sense_fault_out(sf), .fault_flag_n_oe_out(oe),
		.fault_flag_n_out(fo), .overcurrent_threshold_out(thr),
		.fault_state_out(fs), .foldback_active_out(fb));
	// Fixed-limit variant on the same pins, with a moving temperature
	sfpc_fault_ctrl #(.VARIANT(sfpc_pkg::SFPC_VAR_FIXED), .RETRY_CYC(RC))
		uut_f (.mclk_in(mclk_in),
		.resetn_in(resetn_in), .enable_in(en), .diagnostics_enable_in(diag),
		.holdoff_in(hold), .abs_over_in(abs_o), .abs_hys_clear_in(abs_c),
		.rel_over_in(rel_o), .supply_below_fall_in(s_lo),
		.supply_above_rise_in(s_hi), .reverse_battery_in(rev),
		.load_dump_in(ld), .vout_risen_in(vr), .current_in(cur),
		.junction_temp_in(tj), .limit_set_resistor_in(res),
		.default_threshold_in(12'h200), .limit_k_in(12'hA00),
		.switch_on_out(sw_f), .sense_fault_out(sf_f),
		.fault_flag_n_oe_out(oe_f), .fault_flag_n_out(fo_f),
		.overcurrent_threshold_out(thr_f), .fault_state_out(fs_f),
		.foldback_active_out(fb_f));
	task automatic cyc(int n);
		repeat (n) @(posedge mclk_in);
	endtask : cyc
	// Settle, then note expected switch and sense levels
	task automatic note(logic s, logic f);
		cyc(8);
		q.push_back({s, f});
		chk <= 1'b1;
		cyc(1);
		chk <= 1'b0;
	endtask : note
	task automatic cmp(logic [11:0] got, logic [11:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH t=%0t exp=%h got=%h", $time, exp, got);
		end
	endtask : cmp
	task automatic final_report;
		$display("fails=%0d comparisons=%0d", n_fail, comparisons);
		if (n_fail == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : final_report
	// ==========================================================
	// Output watcher takes the oldest note
	always @(negedge mclk_in) if (chk) begin
		e = q.pop_front();
		cmp({10'h000, sw, sf}, {10'h000, e});
		cmp({9'h000, oe, fo, fs}, {11'h000, e[0] & ~e[1]});
		cmp({9'h000, sw_f, sf_f, oe_f}, {9'h000, e, e[0]});
		cmp({11'h000, fo_f}, 12'h000);
	end
	initial begin
		cyc(20000);
		n_fail++;
		final_report();
	end
	// ==========================================================
	// Main sequence
	initial begin
		void'($urandom(32'h786A));
		res <= 8'h1E + 8'($urandom % 200);
		cyc(12);
		resetn_in <= 1'b1;
		cyc(2);
		s_hi <= 1'b1;
		w_en <= 1'b1;
		note(1, 0);
		cmp(thr, 12'h200);
		cmp(thr_f, 12'h200);
		tj <= 9'h069;
		cyc(4);
		cmp(thr_f, 12'h100);
		tj <= 9'h096;
		cyc(4);
		cmp(thr_f, 12'h000);
		tj <= 9'h019;
		res <= 8'h0A;
		cyc(4);
		cmp(thr, 12'hA00 / 12'h00A);
		abs_o <= 1'b1;
		abs_c <= 1'b0;
		note(0, 1);
		abs_o <= 1'b0;
		cyc(2 * RC);
		note(0, 1);
		abs_c <= 1'b1;
		note(1, 1);
		vr <= 1'b1;
		note(1, 0);
		w_hold <= 1'b1;
		rel_o <= 1'b1;
		note(0, 1);
		rel_o <= 1'b0;
		cyc(2 * RC);
		note(0, 1);
		w_hold <= 1'b0;
		note(1, 0);
		cur <= 12'h200 + 12'($urandom % 3583);
		cyc(300);
		note(1, 0);
		cyc(100);
		note(0, 1);
		cur <= 12'h000;
		w_en <= 1'b0;
		note(0, 0);
		w_en <= 1'b1;
		note(1, 0);
		for (int i = 0; i < 7; i++) begin
			cmp({11'h000, fb}, 12'h000);
			rel_o <= 1'b1;
			cyc(8);
			rel_o <= 1'b0;
			cyc(RC + 20);
		end
		cmp({11'h000, fb}, 12'h001);
		cmp(thr, 12'h080);
		w_en <= 1'b0;
		cyc(10);
		cmp(thr, 12'h100);
		rev <= 1'b1;
		note(1, 0);
		rev <= 1'b0;
		w_en <= 1'b1;
		note(1, 0);
		ld <= 1'b1;
		s_lo <= 1'b1;
		s_hi <= 1'b0;
		note(1, 0);
		ld <= 1'b0;
		note(0, 0);
		s_lo <= 1'b0;
		s_hi <= 1'b1;
		note(1, 0);
		final_report();
	end
endmodule : sfpc_fault_ctrl_tb
